// *** exec_pkg.sv ***
// constants and types shared by the bit, flag and memory-transfer executor
// Function
// - bit store copies register bit into transfer flag
// - bit load writes transfer flag into register bit
// - single-cycle set or clear of overflow flag
// - single-cycle set or clear of half-carry flag
// - single-cycle set of signed test flag
// - single-cycle clear of signed test flag
// - pointer load, then post-increment pointer, two cycles
// - pre-decrement pointer, then load, two cycles
// - displacement load from X, Y or Z pointer plus offset, two cycles
// - direct load from constant address, two cycles
// - pointer store, then post-increment pointer, two cycles
// - pre-decrement pointer, then store, two cycles
// - displacement store to pointer plus offset, two cycles
package exec_pkg;
  // ----------------------------------------
  // status register bit positions
  // ----------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;
  // ----------------------------------------
  // pointer pair low register indices and reset values
  // ----------------------------------------
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int unsigned NUM_REGS = 32;
  localparam int unsigned ADDR_W_DEFAULT = 16;
  // ----------------------------------------
  // operations, pointer choice and addressing mode
  // ----------------------------------------
  typedef enum logic [3:0] {
    op_nop,
    op_arith_shift_right,
    op_nibble_swap,
    op_bit_to_transfer_flag,
    op_transfer_flag_to_bit,
    op_flag_set,
    op_flag_clear,
    op_pair_copy,
    op_pointer_load,
    op_offset_load,
    op_direct_load,
    op_pointer_store,
    op_offset_store
  } op_t;
  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} ptr_sel_t;
  typedef enum logic [1:0] {mode_plain, mode_post_inc, mode_pre_dec} ptr_mode_t;
  typedef struct packed {
    op_t op;
    logic [4:0] dst;
    logic [4:0] src;
    logic [2:0] bit_sel;
    ptr_sel_t ptr;
    ptr_mode_t mode;
    logic [5:0] disp;
    logic [15:0] direct_addr;
  } cmd_t;
  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage

// *** addr_unit.sv ***
// effective address and pointer update for data-memory transfers
`timescale 1ns/1ps
module addr_unit
  import exec_pkg::*;
(
  input wire cmd_t cmd,
  input wire logic [15:0] ptr_val,
  output logic [15:0] addr,
  output logic [15:0] ptr_new,
  output logic ptr_wr
);
  always_comb
  begin
    addr = ptr_val;
    ptr_new = ptr_val;
    ptr_wr = 1'b0;
    case (cmd.op)
      op_pointer_load, op_pointer_store:
      begin
        if (cmd.mode == mode_post_inc)
        begin
          ptr_new = ptr_val + 16'h0001;
          ptr_wr = 1'b1;
        end
        else if (cmd.mode == mode_pre_dec)
        begin
          ptr_new = ptr_val - 16'h0001;
          addr = ptr_new;
          ptr_wr = 1'b1;
        end
      end
      op_offset_load, op_offset_store:
        addr = ptr_val + {10'h000, cmd.disp};
      op_direct_load:
        addr = cmd.direct_addr;
      default:
        addr = ptr_val;
    endcase
  end
endmodule

// *** transfer_exec.sv ***
// executor for bit, flag, shift, copy and data-memory transfer instructions
`timescale 1ns/1ps
module transfer_exec
  import exec_pkg::*;
#(
  parameter int unsigned ADDR_W = ADDR_W_DEFAULT
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cmd_t cmd,
  output logic done,
  output mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic [4:0] obs_sel,
  output logic [7:0] obs_data,
  output logic [7:0] status_reg
);
  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (ADDR_W < 8 || ADDR_W > 16)
  begin : bad_addr_w
    $error("ADDR_W must lie between 8 and 16");
  end

  typedef enum logic {phase_idle, phase_mem} state_t;
  typedef struct packed {
    state_t state;
    logic [NUM_REGS-1:0][7:0] regs;
    logic [7:0] flags;
    logic [4:0] load_dst;
    logic is_load;
    mem_req_t mem;
    logic done;
    logic [7:0] obs;
  } core_t;

  core_t s_reg;
  core_t s_next;
  logic take;
  logic [4:0] ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] eff_addr;
  logic [15:0] ptr_new;
  logic ptr_wr;
  logic [7:0] src_val;
  logic [7:0] dst_val;
  logic [7:0] shifted;

  assign cmd_ready = (s_reg.state == phase_idle);
  assign take = cmd_valid && cmd_ready;
  assign done = s_reg.done;
  assign mem_req = s_reg.mem;
  assign obs_data = s_reg.obs;
  assign status_reg = s_reg.flags;
  assign src_val = s_reg.regs[cmd.src];
  assign dst_val = s_reg.regs[cmd.dst];
  assign shifted = {dst_val[7], dst_val[7:1]};

  always_comb
  begin
    case (cmd.ptr)
      ptr_x: ptr_lo = PTR_X_LO;
      ptr_y: ptr_lo = PTR_Y_LO;
      default: ptr_lo = PTR_Z_LO;
    endcase
  end
  assign ptr_val = {s_reg.regs[ptr_lo + 5'h01], s_reg.regs[ptr_lo]};

  addr_unit u_addr (
    .cmd(cmd),
    .ptr_val(ptr_val),
    .addr(eff_addr),
    .ptr_new(ptr_new),
    .ptr_wr(ptr_wr)
  );

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.mem = '0;
    s_next.obs = s_reg.regs[obs_sel];
    case (s_reg.state)
      phase_idle:
      begin
        if (take)
        begin
          case (cmd.op)
            op_arith_shift_right:
            begin
              s_next.regs[cmd.dst] = shifted;
              s_next.flags[FLAG_C] = dst_val[0];
              s_next.flags[FLAG_Z] = (shifted == 8'h00);
              s_next.flags[FLAG_N] = shifted[7];
              s_next.flags[FLAG_V] = shifted[7] ^ dst_val[0];
              s_next.flags[FLAG_S] = dst_val[0];
              s_next.done = 1'b1;
            end
            op_nibble_swap:
            begin
              s_next.regs[cmd.dst] = {dst_val[3:0], dst_val[7:4]};
              s_next.done = 1'b1;
            end
            op_bit_to_transfer_flag:
            begin
              s_next.flags[FLAG_T] = src_val[cmd.bit_sel];
              s_next.done = 1'b1;
            end
            op_transfer_flag_to_bit:
            begin
              s_next.regs[cmd.dst][cmd.bit_sel] = s_reg.flags[FLAG_T];
              s_next.done = 1'b1;
            end
            op_flag_set:
            begin
              s_next.flags[cmd.bit_sel] = 1'b1;
              s_next.done = 1'b1;
            end
            op_flag_clear:
            begin
              s_next.flags[cmd.bit_sel] = 1'b0;
              s_next.done = 1'b1;
            end
            op_pair_copy:
            begin
              s_next.regs[{cmd.dst[4:1], 1'b0}] = s_reg.regs[{cmd.src[4:1], 1'b0}];
              s_next.regs[{cmd.dst[4:1], 1'b1}] = s_reg.regs[{cmd.src[4:1], 1'b1}];
              s_next.done = 1'b1;
            end
            op_pointer_load, op_offset_load, op_direct_load,
            op_pointer_store, op_offset_store:
            begin
              // address goes out next cycle, memory answers before the edge after
              s_next.state = phase_mem;
              s_next.is_load = (cmd.op == op_pointer_load) || (cmd.op == op_offset_load)
                || (cmd.op == op_direct_load);
              s_next.load_dst = cmd.dst;
              s_next.mem.rd_en = s_next.is_load;
              s_next.mem.wr_en = !s_next.is_load;
              s_next.mem.addr = eff_addr & 16'((32'h1 << ADDR_W) - 1);
              s_next.mem.wdata = src_val;
              if (ptr_wr)
              begin
                s_next.regs[ptr_lo] = ptr_new[7:0];
                s_next.regs[ptr_lo + 5'h01] = ptr_new[15:8];
              end
            end
            default:
              s_next.done = 1'b1;
          endcase
        end
      end
      phase_mem:
      begin
        if (s_reg.is_load)
          s_next.regs[s_reg.load_dst] = mem_rdata;
        s_next.state = phase_idle;
        s_next.done = 1'b1;
      end
      default:
        s_next.state = phase_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg.state <= phase_idle;
      s_reg.regs <= {NUM_REGS{REG_RESET}};
      s_reg.flags <= STATUS_RESET;
      s_reg.load_dst <= 5'h00;
      s_reg.is_load <= 1'b0;
      s_reg.mem <= '0;
      s_reg.done <= 1'b0;
      s_reg.obs <= 8'h00;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_take(op_t o);
    take && cmd.op == o;
  endsequence
  sequence s_mem_done;
    ##1 (s_reg.state == phase_mem && !cmd_ready) ##1 (done && cmd_ready);
  endsequence

  AST_BIT_STORE: assert property (s_take(op_bit_to_transfer_flag) |=>
    status_reg[FLAG_T] == $past(src_val[cmd.bit_sel]) && done
    && status_reg[5:0] == $past(status_reg[5:0]))
    else $error("bit store wrong");
  AST_BIT_LOAD: assert property (s_take(op_transfer_flag_to_bit) |=>
    status_reg == $past(status_reg) && done)
    else $error("bit load changed flags");
  AST_OVF_SET: assert property (s_take(op_flag_set) ##0 (cmd.bit_sel == 3'h3) |=>
    status_reg == ($past(status_reg) | 8'h08))
    else $error("overflow set wrong");
  AST_HALF_CLR: assert property (s_take(op_flag_clear) ##0 (cmd.bit_sel == 3'h5) |=>
    status_reg == ($past(status_reg) & 8'hdf))
    else $error("half-carry clear wrong");
  AST_SIGN_SET: assert property (s_take(op_flag_set) ##0 (cmd.bit_sel == 3'h4) |=>
    status_reg[FLAG_S] && done)
    else $error("sign set wrong");
  AST_SIGN_CLR: assert property (s_take(op_flag_clear) ##0 (cmd.bit_sel == 3'h4) |=>
    !status_reg[FLAG_S] && done)
    else $error("sign clear wrong");
  AST_POST_INC_LOAD: assert property (
    s_take(op_pointer_load) ##0 (cmd.mode == mode_post_inc)
    |=> mem_req.rd_en && mem_req.addr == $past(ptr_val))
    else $error("post-increment load address wrong");
  AST_PRE_DEC_STORE: assert property (
    s_take(op_pointer_store) ##0 (cmd.mode == mode_pre_dec)
    |=> mem_req.wr_en && mem_req.addr == $past(ptr_val) - 16'h0001)
    else $error("pre-decrement store address wrong");
  AST_MEM_TWO_CYCLES: assert property (take && (cmd.op == op_direct_load
    || cmd.op == op_offset_store) |-> s_mem_done)
    else $error("memory transfer not two cycles");
  AST_SHIFT_CARRY: assert property (s_take(op_arith_shift_right) |=>
    status_reg[FLAG_C] == $past(dst_val[0]) && status_reg[FLAG_T] == $past(status_reg[FLAG_T]))
    else $error("shift carry wrong");
  AST_SWAP_FLAGS: assert property (s_take(op_nibble_swap) |=>
    status_reg == $past(status_reg))
    else $error("swap changed flags");
endmodule

// *** data_mem_model.sv ***
// behavioural data memory that answers the executor's read and write requests
`timescale 1ns/1ps
module data_mem_model
  import exec_pkg::*;
(
  input wire logic clk,
  input wire mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_reg;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0] ^ 8'ha5;
    last_reg = 8'h00;
  end
  // outside a read the bus shows the inverse of the last value, never a stale copy
  assign mem_rdata = mem_req.rd_en ? mem[mem_req.addr[7:0]] : ~last_reg;
  always @(posedge clk)
  begin
    if (mem_req.wr_en)
      mem[mem_req.addr[7:0]] <= mem_req.wdata;
    if (mem_req.rd_en)
      last_reg <= mem[mem_req.addr[7:0]];
  end
endmodule

// *** test_transfer_exec.sv ***
// self-checking bench for the bit, flag and memory-transfer executor
`timescale 1ns/1ps
module test_transfer_exec;
  import exec_pkg::*;
  logic clk;
  logic rstn;
  logic cmd_valid;
  logic cmd_ready;
  cmd_t cmd;
  logic done;
  mem_req_t mem_req;
  logic [7:0] mem_rdata;
  logic [4:0] obs_sel;
  logic [7:0] obs_data;
  logic [7:0] status_reg;
  logic [7:0] exp_flags;
  int errors;
  int tests_run;

  transfer_exec #(.ADDR_W(16)) transfer_exec_i (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .done(done), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .obs_sel(obs_sel), .obs_data(obs_data), .status_reg(status_reg));
  data_mem_model data_mem_model_i (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic cmd_t mop(op_t op, logic [4:0] r, ptr_sel_t p, ptr_mode_t m,
                               logic [5:0] q, logic [15:0] a);
    mop = '{op, r, r, 3'h0, p, m, q, a};
  endfunction
  function automatic cmd_t sop(op_t op, logic [4:0] d, logic [4:0] s, logic [2:0] b);
    sop = '{op, d, s, b, ptr_x, mode_plain, 6'h00, 16'h0000};
  endfunction
  // k: 2'b10 read, 2'b01 write, 2'b00 no memory traffic; status must equal exp_flags at done
  task automatic run(input cmd_t c, input int lat, input logic [1:0] k,
                     input logic [15:0] a, input logic [7:0] wd);
    int n;
    mem_req_t rq;
    logic rdy;
    @(negedge clk);
    cmd = c;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 1;
    rq = mem_req;
    rdy = cmd_ready;
    while (done !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, lat);
    chk({rq.rd_en, rq.wr_en}, k);
    if (k != 2'b00)
      chk(rq.addr, a);
    if (k != 2'b00)
      chk(rdy, 1'b0);
    if (k == 2'b01)
      chk(rq.wdata, wd);
    chk(status_reg, exp_flags);
  endtask
  task automatic peek(input logic [4:0] r, input logic [7:0] e);
    @(negedge clk);
    obs_sel = r;
    @(negedge clk);
    chk(obs_data, e);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(status_reg, 8'h00);
    chk(cmd_ready, 1'b1);
    chk(done, 1'b0);
    peek(5'h10, 8'h00);
  endtask
  task automatic t_direct();
    logic [4:0] dr [7];
    logic [7:0] da [7];
    cmd_t c;
    dr = '{5'h10, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
    da = '{8'h40, 8'h10, 8'ha5, 8'h20, 8'ha5, 8'h30, 8'ha5};
    for (int i = 0; i < 7; i++)
    begin
      c = mop(op_direct_load, dr[i], ptr_x, mode_plain, 6'h00, {8'h00, da[i]});
      run(c, 2, 2'b10, {8'h00, da[i]}, 8'h00);
      peek(dr[i], da[i] ^ 8'ha5);
    end
  endtask
  task automatic t_ptr_load();
    run(mop(op_pointer_load, 5'h01, ptr_x, mode_post_inc, 6'h00, 16'h0), 2, 2'b10, 16'h00b5, 0);
    peek(5'h01, 8'h10);
    peek(5'h1a, 8'hb6);
    run(mop(op_pointer_load, 5'h02, ptr_y, mode_pre_dec, 6'h00, 16'h0), 2, 2'b10, 16'h0084, 0);
    peek(5'h02, 8'h21);
    peek(5'h1c, 8'h84);
    run(mop(op_offset_load, 5'h03, ptr_z, mode_plain, 6'h3f, 16'h0), 2, 2'b10, 16'h00d4, 0);
    peek(5'h03, 8'h71);
    peek(5'h1e, 8'h95);
    run(mop(op_pointer_load, 5'h08, ptr_z, mode_plain, 6'h00, 16'h0), 2, 2'b10, 16'h0095, 8'h00);
    peek(5'h08, 8'h30);
    peek(5'h1e, 8'h95);
  endtask
  task automatic t_store();
    run(mop(op_pointer_store, 5'h10, ptr_x, mode_post_inc, 6'h00, 16'h0), 2, 2'b01, 16'h00b6, 8'he5);
    peek(5'h1a, 8'hb7);
    run(mop(op_direct_load, 5'h04, ptr_x, mode_plain, 6'h00, 16'h00b6), 2, 2'b10, 16'h00b6, 0);
    peek(5'h04, 8'he5);
    run(mop(op_pointer_store, 5'h01, ptr_y, mode_pre_dec, 6'h00, 16'h0), 2, 2'b01, 16'h0083, 8'h10);
    peek(5'h1c, 8'h83);
    run(mop(op_offset_store, 5'h10, ptr_y, mode_plain, 6'h01, 16'h0), 2, 2'b01, 16'h0084, 8'he5);
    peek(5'h1c, 8'h83);
    run(mop(op_direct_load, 5'h06, ptr_x, mode_plain, 6'h00, 16'h0083), 2, 2'b10, 16'h0083, 8'h00);
    peek(5'h06, 8'h10);
    run(mop(op_direct_load, 5'h07, ptr_x, mode_plain, 6'h00, 16'h0084), 2, 2'b10, 16'h0084, 8'h00);
    peek(5'h07, 8'he5);
  endtask
  task automatic t_bits();
    exp_flags = 8'h40;
    run(sop(op_bit_to_transfer_flag, 5'h00, 5'h10, 3'h2), 1, 2'b00, 0, 0);
    exp_flags = 8'h00;
    run(sop(op_bit_to_transfer_flag, 5'h00, 5'h10, 3'h1), 1, 2'b00, 0, 0);
    exp_flags = 8'h40;
    run(sop(op_bit_to_transfer_flag, 5'h00, 5'h10, 3'h2), 1, 2'b00, 0, 0);
    run(sop(op_transfer_flag_to_bit, 5'h10, 5'h00, 3'h1), 1, 2'b00, 0, 0);
    peek(5'h10, 8'he7);
  endtask
  task automatic t_flags();
    logic [2:0] fi [3];
    fi = '{3'h3, 3'h5, 3'h4};
    for (int i = 0; i < 3; i++)
    begin
      exp_flags[fi[i]] = 1'b1;
      run(sop(op_flag_set, 5'h00, 5'h00, fi[i]), 1, 2'b00, 0, 0);
      exp_flags[fi[i]] = 1'b0;
      run(sop(op_flag_clear, 5'h00, 5'h00, fi[i]), 1, 2'b00, 0, 0);
    end
  endtask
  task automatic t_alu();
    exp_flags = 8'h55;
    run(sop(op_arith_shift_right, 5'h10, 5'h10, 3'h0), 1, 2'b00, 0, 0);
    peek(5'h10, 8'hf3);
    run(sop(op_nibble_swap, 5'h03, 5'h03, 3'h0), 1, 2'b00, 0, 0);
    peek(5'h03, 8'h17);
    run(sop(op_pair_copy, 5'h05, 5'h03, 3'h0), 1, 2'b00, 0, 0);
    peek(5'h04, 8'h21);
    peek(5'h05, 8'h17);
  endtask

  task automatic print_verdict();
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    obs_sel = 5'h00;
    exp_flags = 8'h00;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_direct();
    t_ptr_load();
    t_store();
    t_bits();
    t_flags();
    t_alu();
    print_verdict();
  end
  initial
  begin
    #20000;
    errors++;
    print_verdict();
  end
endmodule
